// file: tcc_pkg.sv
// shared constants, register map and mode decode for the 16-bit capture timer
package tcc_pkg;

  // ----------------------------------------------------------------
  // register map (byte locations on the 8-bit bus)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CAP_LO = 3'h4;
  localparam logic [2:0] ADDR_CAP_HI = 3'h5;
  localparam logic [2:0] ADDR_FLAGS = 3'h6;
  localparam logic [2:0] ADDR_MASK = 3'h7;
  localparam logic [2:0] ADDR_HI_STEP = 3'h1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CA_WGM_LSB = 0;
  localparam int CB_CS_LSB = 0;
  localparam int CB_WGM_LSB = 3;
  localparam int CB_EDGE = 6;
  localparam int CB_FILT = 7;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CAP = 5;

  // ----------------------------------------------------------------
  // values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam int FILTER_SAMPLES = 4;
  localparam int PRESC_W = 10;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03F;
  localparam logic [9:0] DIV256_MASK = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;

  // ----------------------------------------------------------------
  // tick source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_CLK = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_FIRST = 3'b001,
    HS_SECOND = 3'b010,
    HS_FINISH = 3'b011,
    HS_DONE = 3'b100
  } tcc_hstate_t;

  // ----------------------------------------------------------------
  // waveform mode decode
  // ----------------------------------------------------------------
  function automatic logic wgm_dual(input logic [3:0] m);
    return m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
  endfunction

  function automatic logic wgm_cap_top(input logic [3:0] m);
    return m inside {4'h8, 4'hA, 4'hC, 4'hE};
  endfunction

  function automatic logic wgm_ovf_at_top(input logic [3:0] m);
    return m inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  endfunction

  // compare-register tops are not built here, so those modes run to MAX
  function automatic logic [15:0] wgm_top(input logic [3:0] m, input logic [15:0] cap);
    logic [15:0] t;
    t = CNT_MAX;
    if (m inside {4'h1, 4'h5}) t = TOP_8;
    if (m inside {4'h2, 4'h6}) t = TOP_9;
    if (m inside {4'h3, 4'h7}) t = TOP_10;
    if (wgm_cap_top(m)) t = cap;
    return t;
  endfunction

endpackage

// file: tcc_if.sv
// byte bus and interrupt lines between processor end and timer end
`timescale 1ns/1ps
interface tcc_if;
  logic [2:0] addr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ovf_irq;
  logic cap_irq;
  logic ovf_ack;
  logic cap_ack;

  modport dev(
    input addr, wr_en, rd_en, wdata, ovf_ack, cap_ack,
    output rdata, ovf_irq, cap_irq
  );
  modport host(
    output addr, wr_en, rd_en, wdata, ovf_ack, cap_ack,
    input rdata, ovf_irq, cap_irq
  );
endinterface

// file: tcc_capture_front.sv
// capture source sync, four-sample filter and edge detector
`timescale 1ns/1ps
module tcc_capture_front (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic pin_raw,
  input wire logic comp_raw,
  input wire logic comp_sel,
  input wire logic filter_en,
  input wire logic rising,
  input wire logic enable,
  output logic capture
);

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic cmp_s1;
    logic cmp_s2;
    logic [tcc_pkg::FILTER_SAMPLES-1:0] hist;
    logic filt;
    logic last;
    logic capture;
  } tcc_front_t;

  tcc_front_t q;
  tcc_front_t d;
  logic src;

  // ----------------------------------------------------------------
  // filter and edge
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.pin_s1 = pin_raw;
    d.pin_s2 = q.pin_s1;
    d.cmp_s1 = comp_raw;
    d.cmp_s2 = q.cmp_s1;
    // switching the source can itself look like an edge
    src = comp_sel ? q.cmp_s2 : q.pin_s2;
    d.hist = {q.hist[tcc_pkg::FILTER_SAMPLES-2:0], src};
    if (!filter_en) begin
      d.filt = src;
    end else if (&q.hist) begin
      d.filt = 1'b1;
    end else if (~|q.hist) begin
      d.filt = 1'b0;
    end
    d.last = q.filt;
    d.capture = enable && (rising ? (q.filt && !q.last) : (!q.filt && q.last));
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign capture = q.capture;

endmodule

// file: tcc_device.sv
// timer end: 16-bit up/down counter, shared high latch, input capture
`timescale 1ns/1ps
// Notes on behaviour
// - software masks interrupts around two-byte accesses
// - latch keeps its value across many low writes
// - tick source select; zero stops counting only
// - host count write beats any count step
// - sixteen-bit counter steps by one either way
// - each tick clears, increments or decrements per mode
// - bottom at zero, top at sequence top
// - high count location reaches only the latch
// - low read fills latch; low write loads high
// - four-bit mode split over both controls
// - overflow flag set where mode says; interrupts
// - pin or comparator edge triggers capture
// - capture copies count and sets flag together
// - enabled flag interrupts; servicing clears it
// - writing one to capture flag clears it
// - capture read low first, high from latch
// - capture writable only in capture-top modes
// - capture load writes high byte first
// - one latch shared; low reads and high writes load it
// - write high first, read low first
// - filter needs four equal samples, four cycles
module tcc_device (
  input wire logic mclk,
  input wire logic resetn,
  tcc_if.dev bus,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic comparator_capture_select,
  input wire logic t1_pin,
  output logic counter_top,
  output logic counter_bottom,
  output logic count_down
);

  typedef struct packed {
    logic [3:0] wgm;
    logic [2:0] cs;
    logic edge_rise;
    logic filt;
    logic mask_ovf;
    logic mask_cap;
    logic flag_ovf;
    logic flag_cap;
    logic [7:0] latch;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic dir_down;
    logic [tcc_pkg::PRESC_W-1:0] presc;
    logic t1_s1;
    logic t1_s2;
    logic t1_last;
    logic [7:0] rdata;
  } tcc_dev_t;

  tcc_dev_t q;
  tcc_dev_t d;
  logic tick;
  logic dual;
  logic fast;
  logic cap_top;
  logic [15:0] top;
  logic capture_evt;
  logic cnt_wr;
  logic ovf_set;
  logic ovf_clr;
  logic cap_clr;
  logic [7:0] rd_byte;

  assign dual = tcc_pkg::wgm_dual(q.wgm);
  assign fast = tcc_pkg::wgm_ovf_at_top(q.wgm);
  assign cap_top = tcc_pkg::wgm_cap_top(q.wgm);
  assign top = tcc_pkg::wgm_top(q.wgm, q.cap);
  assign cnt_wr = bus.wr_en && (bus.addr == tcc_pkg::ADDR_CNT_LO);

  // ----------------------------------------------------------------
  // capture front end
  // ----------------------------------------------------------------
  // capture events are blocked while the capture register serves as top
  tcc_capture_front i_tcc_capture_front (
    .mclk(mclk),
    .resetn(resetn),
    .pin_raw(capture_pin),
    .comp_raw(comparator_output),
    .comp_sel(comparator_capture_select),
    .filter_en(q.filt),
    .rising(q.edge_rise),
    .enable(!cap_top),
    .capture(capture_evt)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ovf_set = 1'b0;
    rd_byte = tcc_pkg::BYTE_ZERO;
    d.t1_s1 = t1_pin;
    d.t1_s2 = q.t1_s1;
    d.t1_last = q.t1_s2;
    d.presc = (q.cs == tcc_pkg::CS_STOP) ? '0 : q.presc + 1'b1;

    unique case (q.cs)
      tcc_pkg::CS_STOP: tick = 1'b0;
      tcc_pkg::CS_CLK: tick = 1'b1;
      tcc_pkg::CS_DIV8: tick = (q.presc & tcc_pkg::DIV8_MASK) == tcc_pkg::DIV8_MASK;
      tcc_pkg::CS_DIV64: tick = (q.presc & tcc_pkg::DIV64_MASK) == tcc_pkg::DIV64_MASK;
      tcc_pkg::CS_DIV256: tick = (q.presc & tcc_pkg::DIV256_MASK) == tcc_pkg::DIV256_MASK;
      tcc_pkg::CS_DIV1024: tick = (q.presc & tcc_pkg::DIV1024_MASK) == tcc_pkg::DIV1024_MASK;
      tcc_pkg::CS_EXT_FALL: tick = q.t1_last && !q.t1_s2;
      tcc_pkg::CS_EXT_RISE: tick = !q.t1_last && q.t1_s2;
    endcase

    // counting sequence
    if (tick) begin
      if (dual) begin
        if (!q.dir_down) begin
          if (q.cnt == top) begin
            d.dir_down = 1'b1;
            d.cnt = q.cnt - 1'b1;
          end else begin
            d.cnt = q.cnt + 1'b1;
          end
        end else if (q.cnt == tcc_pkg::CNT_BOTTOM) begin
          d.dir_down = 1'b0;
          d.cnt = q.cnt + 1'b1;
          ovf_set = 1'b1;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end else begin
        d.dir_down = 1'b0;
        if (q.cnt == top) begin
          d.cnt = tcc_pkg::CNT_BOTTOM;
          ovf_set = fast || (q.cnt == tcc_pkg::CNT_MAX);
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
    end
    if (cnt_wr) begin
      d.cnt = {q.latch, bus.wdata};
    end

    // reads: the low half of a wide register fills the latch
    if (bus.rd_en) begin
      unique case (bus.addr)
        tcc_pkg::ADDR_CTRL_A: begin
          rd_byte[tcc_pkg::CA_WGM_LSB +: 2] = q.wgm[1:0];
        end
        tcc_pkg::ADDR_CTRL_B: begin
          rd_byte[tcc_pkg::CB_CS_LSB +: 3] = q.cs;
          rd_byte[tcc_pkg::CB_WGM_LSB +: 2] = q.wgm[3:2];
          rd_byte[tcc_pkg::CB_EDGE] = q.edge_rise;
          rd_byte[tcc_pkg::CB_FILT] = q.filt;
        end
        tcc_pkg::ADDR_CNT_LO: begin
          rd_byte = q.cnt[7:0];
          d.latch = q.cnt[15:8];
        end
        tcc_pkg::ADDR_CAP_LO: begin
          rd_byte = q.cap[7:0];
          d.latch = q.cap[15:8];
        end
        tcc_pkg::ADDR_CNT_HI, tcc_pkg::ADDR_CAP_HI: begin
          rd_byte = q.latch;
        end
        tcc_pkg::ADDR_FLAGS: begin
          rd_byte[tcc_pkg::FLAG_OVF] = q.flag_ovf;
          rd_byte[tcc_pkg::FLAG_CAP] = q.flag_cap;
        end
        tcc_pkg::ADDR_MASK: begin
          rd_byte[tcc_pkg::FLAG_OVF] = q.mask_ovf;
          rd_byte[tcc_pkg::FLAG_CAP] = q.mask_cap;
        end
      endcase
      d.rdata = rd_byte;
    end

    // writes
    if (bus.wr_en) begin
      unique case (bus.addr)
        tcc_pkg::ADDR_CTRL_A: begin
          d.wgm[1:0] = bus.wdata[tcc_pkg::CA_WGM_LSB +: 2];
        end
        tcc_pkg::ADDR_CTRL_B: begin
          d.cs = bus.wdata[tcc_pkg::CB_CS_LSB +: 3];
          d.wgm[3:2] = bus.wdata[tcc_pkg::CB_WGM_LSB +: 2];
          d.edge_rise = bus.wdata[tcc_pkg::CB_EDGE];
          d.filt = bus.wdata[tcc_pkg::CB_FILT];
        end
        tcc_pkg::ADDR_CNT_HI, tcc_pkg::ADDR_CAP_HI: begin
          d.latch = bus.wdata;
        end
        tcc_pkg::ADDR_CAP_LO: begin
          if (cap_top) begin
            d.cap = {q.latch, bus.wdata};
          end
        end
        tcc_pkg::ADDR_MASK: begin
          d.mask_ovf = bus.wdata[tcc_pkg::FLAG_OVF];
          d.mask_cap = bus.wdata[tcc_pkg::FLAG_CAP];
        end
        tcc_pkg::ADDR_CNT_LO, tcc_pkg::ADDR_FLAGS: begin
        end
      endcase
    end

    // capture; never coincides with a host load as modes exclude each other
    if (capture_evt) begin
      d.cap = q.cnt;
    end

    // flags: a new event wins over a clear in the same cycle
    ovf_clr = (bus.wr_en && bus.addr == tcc_pkg::ADDR_FLAGS && bus.wdata[tcc_pkg::FLAG_OVF])
      || bus.ovf_ack;
    cap_clr = (bus.wr_en && bus.addr == tcc_pkg::ADDR_FLAGS && bus.wdata[tcc_pkg::FLAG_CAP])
      || bus.cap_ack;
    d.flag_ovf = ovf_set || (q.flag_ovf && !ovf_clr);
    d.flag_cap = capture_evt || (q.flag_cap && !cap_clr);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.rdata = q.rdata;
  assign bus.ovf_irq = q.flag_ovf && q.mask_ovf;
  assign bus.cap_irq = q.flag_cap && q.mask_cap;
  assign counter_top = (q.cnt == top);
  assign counter_bottom = (q.cnt == tcc_pkg::CNT_BOTTOM);
  assign count_down = q.dir_down;

endmodule

// file: tcc_host.sv
// processor end: byte sequencer for wide timer registers and interrupt service
`timescale 1ns/1ps
module tcc_host (
  input wire logic mclk,
  input wire logic resetn,
  tcc_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_wide,
  input wire logic [2:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic ack,
  output logic [15:0] rdata,
  output logic ovf_serviced,
  output logic cap_serviced
);

  typedef struct packed {
    tcc_pkg::tcc_hstate_t st;
    logic is_wr;
    logic wide;
    logic [2:0] base;
    logic [15:0] wval;
    logic [2:0] bus_addr;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_wdata;
    logic [15:0] rdata;
    logic ovf_ack;
    logic cap_ack;
  } tcc_host_t;

  tcc_host_t q;
  tcc_host_t d;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.bus_wr = 1'b0;
    d.bus_rd = 1'b0;
    d.ovf_ack = 1'b0;
    d.cap_ack = 1'b0;
    unique case (q.st)
      tcc_pkg::HS_IDLE: begin
        if (req) begin
          d.is_wr = req_write;
          d.wide = req_wide;
          d.base = req_addr;
          d.wval = req_wdata;
          d.bus_wr = req_write;
          d.bus_rd = !req_write;
          d.st = tcc_pkg::HS_FIRST;
          if (req_wide && req_write) begin
            d.bus_addr = req_addr + tcc_pkg::ADDR_HI_STEP;
            d.bus_wdata = req_wdata[15:8];
          end else begin
            d.bus_addr = req_addr;
            d.bus_wdata = req_wdata[7:0];
          end
        end else begin
          // service only between transfers so the latch is never disturbed
          d.ovf_ack = bus.ovf_irq && !q.ovf_ack;
          d.cap_ack = bus.cap_irq && !q.cap_ack;
        end
      end
      tcc_pkg::HS_FIRST: begin
        if (q.wide) begin
          d.bus_wr = q.is_wr;
          d.bus_rd = !q.is_wr;
          d.bus_addr = q.is_wr ? q.base : q.base + tcc_pkg::ADDR_HI_STEP;
          d.bus_wdata = q.wval[7:0];
          d.st = tcc_pkg::HS_SECOND;
        end else begin
          d.st = tcc_pkg::HS_FINISH;
        end
      end
      tcc_pkg::HS_SECOND: begin
        if (!q.is_wr) begin
          d.rdata[7:0] = bus.rdata;
        end
        d.st = tcc_pkg::HS_FINISH;
      end
      tcc_pkg::HS_FINISH: begin
        if (!q.is_wr) begin
          if (q.wide) begin
            d.rdata[15:8] = bus.rdata;
          end else begin
            d.rdata = {tcc_pkg::BYTE_ZERO, bus.rdata};
          end
        end
        d.st = tcc_pkg::HS_DONE;
      end
      tcc_pkg::HS_DONE: begin
        d.st = tcc_pkg::HS_IDLE;
      end
      default: begin
        d.st = tcc_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.addr = q.bus_addr;
  assign bus.wr_en = q.bus_wr;
  assign bus.rd_en = q.bus_rd;
  assign bus.wdata = q.bus_wdata;
  assign bus.ovf_ack = q.ovf_ack;
  assign bus.cap_ack = q.cap_ack;
  assign req_ready = (q.st == tcc_pkg::HS_IDLE);
  assign ack = (q.st == tcc_pkg::HS_DONE);
  assign rdata = q.rdata;
  assign ovf_serviced = q.ovf_ack;
  assign cap_serviced = q.cap_ack;

endmodule

// file: tcc_sva.sv
// checker for the byte bus between processor end and timer end
`timescale 1ns/1ps
module tcc_sva (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ovf_irq,
  input wire logic cap_irq,
  input wire logic ovf_ack,
  input wire logic cap_ack
);
  // ------------------------------------------------------------
  // latch shadow, valid from a high write until a low read
  // ------------------------------------------------------------
  logic [8:0] lat_q;
  logic [8:0] lat_d;
  logic hi_a;
  logic lo_a;
  assign hi_a = addr == tcc_pkg::ADDR_CNT_HI || addr == tcc_pkg::ADDR_CAP_HI;
  assign lo_a = addr == tcc_pkg::ADDR_CNT_LO || addr == tcc_pkg::ADDR_CAP_LO;
  always_comb begin
    lat_d = lat_q;
    if (wr_en && hi_a) lat_d = {1'b1, wdata};
    if (rd_en && lo_a) lat_d = 9'h000;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) lat_q <= 9'h000;
    else lat_q <= lat_d;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_irq_seen;
    cap_irq && !cap_ack;
  endsequence
  sequence s_serviced;
    s_irq_seen ##1 cap_ack;
  endsequence
  a_strobe_excl: assert property (!(wr_en && rd_en))
    else $error("read and write strobes together");
  a_latch_readback: assert property (rd_en && hi_a && lat_q[8] |=> rdata == $past(lat_q[7:0]))
    else $error("high location did not return the latch");
  a_wide_write_order: assert property (wr_en && lo_a && $past(wr_en) |-> $past(addr) == addr + 3'h1)
    else $error("low byte written before its high byte");
  a_ack_one_cycle: assert property (cap_ack |=> !cap_ack)
    else $error("capture service pulse too long");
  a_service_clears: assert property (s_serviced |=> !cap_irq)
    else $error("capture request stayed after service");
  a_flag_write_clear: assert property (wr_en && addr == tcc_pkg::ADDR_FLAGS
      && wdata[tcc_pkg::FLAG_CAP] |=> !cap_irq)
    else $error("writing one did not clear capture flag");
  a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
    else $error("read byte changed without a read");
  a_ovf_irq_holds: assert property (ovf_irq && !ovf_ack && !wr_en |=> ovf_irq)
    else $error("overflow request dropped by itself");
endmodule

// file: timer16_counter_capture_test.sv
// self-checking bench: processor end and timer end joined by the byte bus
`timescale 1ns/1ps
module timer16_counter_capture_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_wide = 1'b0;
  logic [2:0] req_addr = 3'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] rdata, q;
  logic req_ready, ack, ovf_serviced, cap_serviced, counter_top, counter_bottom, count_down;
  logic capture_pin = 1'b0;
  logic comparator_output = 1'b0;
  logic comparator_capture_select = 1'b0;
  logic t1_pin = 1'b0;
  int error_cnt = 0;
  int comparisons = 0;
  int wt;
  tcc_if bus ();
  tcc_host i_tcc_host (.mclk(mclk), .resetn(resetn), .bus(bus.host), .req(req),
    .req_write(req_write), .req_wide(req_wide), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .ack(ack), .rdata(rdata), .ovf_serviced(ovf_serviced),
    .cap_serviced(cap_serviced));
  tcc_device i_tcc_device (.mclk(mclk), .resetn(resetn), .bus(bus.dev),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .comparator_capture_select(comparator_capture_select), .t1_pin(t1_pin),
    .counter_top(counter_top), .counter_bottom(counter_bottom), .count_down(count_down));
  tcc_sva i_tcc_sva (.mclk(mclk), .resetn(resetn), .addr(bus.addr), .wr_en(bus.wr_en),
    .rd_en(bus.rd_en), .wdata(bus.wdata), .rdata(bus.rdata), .ovf_irq(bus.ovf_irq),
    .cap_irq(bus.cap_irq), .ovf_ack(bus.ovf_ack), .cap_ack(bus.cap_ack));
  initial forever #25 mclk = ~mclk;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim, input string n);
    wt = 0;
    while (s !== 1'b1 && wt < lim) begin
      cyc(1);
      wt++;
    end
    chk(n, 16'h0001, {15'h0000, s});
    if (wt >= lim) test_done();
  endtask
  task automatic xfer(input logic w, input logic wd, input logic [2:0] a, input logic [15:0] d);
    wait_hi(req_ready, 20, "ready");
    req = 1'b1;
    req_write = w;
    req_wide = wd;
    req_addr = a;
    req_wdata = d;
    cyc(1);
    req = 1'b0;
    wait_hi(ack, 20, "ack");
    q = rdata;
    cyc(1);
  endtask
  task automatic wb(input logic [2:0] a, input logic [7:0] d);
    xfer(1'b1, 1'b0, a, {8'h00, d});
  endtask
  task automatic rb(input logic [2:0] a);
    xfer(1'b0, 1'b0, a, 16'h0000);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_count();
    chk("bottom", 16'h0001, {15'h0000, counter_bottom});
    xfer(1'b1, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h01FF);
    xfer(1'b0, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h0000);
    chk("count", 16'h01FF, q);
    wb(tcc_pkg::ADDR_CNT_HI, 8'hA5);
    wb(tcc_pkg::ADDR_CNT_LO, 8'h11);
    wb(tcc_pkg::ADDR_CNT_LO, 8'h22);
    xfer(1'b0, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h0000);
    chk("count reuse", 16'hA522, q);
    wb(tcc_pkg::ADDR_CNT_HI, 8'h3C);
    rb(tcc_pkg::ADDR_CNT_HI);
    chk("latch", 16'h003C, q);
    xfer(1'b0, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h0000);
    chk("count kept", 16'hA522, q);
    rb(tcc_pkg::ADDR_CAP_HI);
    chk("shared latch", 16'h00A5, q);
  endtask
  task automatic t_tick();
    logic [2:0] cs [4];
    logic [15:0] inc [4];
    // divide by 8 sees three ticks in the 28 cycles between the two control writes
    cs = '{tcc_pkg::CS_EXT_RISE, tcc_pkg::CS_EXT_FALL, tcc_pkg::CS_DIV8, tcc_pkg::CS_STOP};
    inc = '{16'h0003, 16'h0003, 16'h0003, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      wb(tcc_pkg::ADDR_FLAGS, 8'hFF);
      xfer(1'b1, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'hFFFE);
      wb(tcc_pkg::ADDR_CTRL_B, {5'h00, cs[i]});
      repeat (3) begin
        t1_pin = 1'b1;
        cyc(4);
        t1_pin = 1'b0;
        cyc(4);
      end
      wb(tcc_pkg::ADDR_CTRL_B, 8'h00);
      xfer(1'b0, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h0000);
      chk("ticks", 16'hFFFE + inc[i], q);
      rb(tcc_pkg::ADDR_FLAGS);
      chk("wrap flag", {15'h0000, inc[i] != 16'h0000}, q);
    end
  endtask
  task automatic t_modes();
    wb(tcc_pkg::ADDR_FLAGS, 8'hFF);
    wb(tcc_pkg::ADDR_MASK, 8'h01);
    wb(tcc_pkg::ADDR_CTRL_A, 8'h01);
    xfer(1'b1, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h00FA);
    wb(tcc_pkg::ADDR_CTRL_B, {5'h00, tcc_pkg::CS_CLK});
    wait_hi(counter_top, 20, "top");
    cyc(3);
    chk("down", 16'h0001, {15'h0000, count_down});
    wait_hi(counter_bottom, 600, "bottom");
    wait_hi(ovf_serviced, 10, "ovf at bottom");
    wb(tcc_pkg::ADDR_CTRL_B, 8'h00);
    xfer(1'b1, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h00F0);
    wb(tcc_pkg::ADDR_CTRL_B, {5'h01, tcc_pkg::CS_CLK});
    wait_hi(ovf_serviced, 40, "ovf at top");
    chk("up", 16'h0000, {15'h0000, count_down});
    wb(tcc_pkg::ADDR_CTRL_B, 8'h00);
    wb(tcc_pkg::ADDR_CTRL_A, 8'h00);
    wb(tcc_pkg::ADDR_MASK, 8'h00);
  endtask
  task automatic t_capture();
    int d0;
    wb(tcc_pkg::ADDR_FLAGS, 8'hFF);
    xfer(1'b1, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h4321);
    wb(tcc_pkg::ADDR_CTRL_B, 8'h40);
    capture_pin = 1'b1;
    cyc(12);
    rb(tcc_pkg::ADDR_FLAGS);
    chk("cap flag", 16'h0020, q);
    xfer(1'b0, 1'b1, tcc_pkg::ADDR_CAP_LO, 16'h0000);
    chk("capture", 16'h4321, q);
    wb(tcc_pkg::ADDR_FLAGS, 8'h20);
    xfer(1'b1, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h5678);
    capture_pin = 1'b0;
    cyc(12);
    rb(tcc_pkg::ADDR_FLAGS);
    chk("wrong edge", 16'h0000, q);
    wb(tcc_pkg::ADDR_CTRL_B, 8'h00);
    capture_pin = 1'b1;
    cyc(12);
    capture_pin = 1'b0;
    cyc(12);
    xfer(1'b0, 1'b1, tcc_pkg::ADDR_CAP_LO, 16'h0000);
    chk("falling capture", 16'h5678, q);
    xfer(1'b1, 1'b1, tcc_pkg::ADDR_CNT_LO, 16'h0ABC);
    comparator_capture_select = 1'b1;
    wb(tcc_pkg::ADDR_CTRL_B, 8'h40);
    comparator_output = 1'b1;
    cyc(12);
    xfer(1'b0, 1'b1, tcc_pkg::ADDR_CAP_LO, 16'h0000);
    chk("comparator capture", 16'h0ABC, q);
    comparator_capture_select = 1'b0;
    wb(tcc_pkg::ADDR_FLAGS, 8'hFF);
    wb(tcc_pkg::ADDR_MASK, 8'h20);
    for (int f = 0; f < 2; f++) begin
      wb(tcc_pkg::ADDR_CTRL_B, {f[0], 7'h40});
      cyc(12);
      capture_pin = 1'b1;
      wait_hi(cap_serviced, 40, "cap service");
      if (f == 0) d0 = wt;
      else chk("filter delay", 16'(d0 + tcc_pkg::FILTER_SAMPLES), 16'(wt));
      cyc(2);
      rb(tcc_pkg::ADDR_FLAGS);
      chk("auto clear", 16'h0000, q);
      capture_pin = 1'b0;
      cyc(12);
    end
    wb(tcc_pkg::ADDR_MASK, 8'h00);
  endtask
  task automatic t_cap_write();
    xfer(1'b1, 1'b1, tcc_pkg::ADDR_CAP_LO, 16'h1234);
    xfer(1'b0, 1'b1, tcc_pkg::ADDR_CAP_LO, 16'h0000);
    chk("cap write refused", 16'h0ABC, q);
    wb(tcc_pkg::ADDR_CTRL_B, 8'h18);
    xfer(1'b1, 1'b1, tcc_pkg::ADDR_CAP_LO, 16'h1234);
    xfer(1'b0, 1'b1, tcc_pkg::ADDR_CAP_LO, 16'h0000);
    chk("cap write", 16'h1234, q);
    wb(tcc_pkg::ADDR_CTRL_B, 8'h00);
  endtask
  initial begin
    cyc(20);
    resetn = 1'b1;
    cyc(1);
    t_count();
    t_tick();
    t_modes();
    t_capture();
    t_cap_write();
    test_done();
  end
endmodule
